// ==== rtl/almc_pkg.sv ====
// Purpose: shared constants of the ambient light measurement control
// Assumes: aclk at 250 MHz
// Notes:   register offsets are byte addresses on the control bus
package almc_pkg;
    // clock rate
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned CYC_PER_MS   = CLK_MHZ * 1000;
    // times in milliseconds
    localparam int unsigned SHORT_MS     = 100;
    localparam int unsigned LONG_MS      = 800;
    localparam int unsigned FINISH_MS    = 3;
    localparam int unsigned ASSESS_MS    = 10;
    localparam int unsigned TIMEOUT_MS   = 28;
    // same times in clock cycles
    localparam int unsigned SHORT_CYC    = SHORT_MS * CYC_PER_MS;
    localparam int unsigned LONG_CYC     = LONG_MS * CYC_PER_MS;
    localparam int unsigned FINISH_CYC   = FINISH_MS * CYC_PER_MS;
    localparam int unsigned ASSESS_CYC   = ASSESS_MS * CYC_PER_MS;
    localparam int unsigned TIMEOUT_CYC  = TIMEOUT_MS * CYC_PER_MS;
    localparam int unsigned CNT_W        = 28;
    // data widths
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned RAW_W        = 20;
    // register byte offsets
    localparam logic [7:0]  OFF_CONFIG   = 8'h00;
    localparam logic [7:0]  OFF_RESULT   = 8'h04;
    localparam logic [7:0]  OFF_LOW_LIM  = 8'h08;
    localparam logic [7:0]  OFF_HIGH_LIM = 8'h0c;
    localparam logic [7:0]  OFF_STATUS   = 8'h10;
    localparam logic [7:0]  OFF_MASK     = 8'h14;
    localparam logic [7:0]  OFF_STATE    = 8'h18;
    // config fields: [1:0] mode, [2] period select, [6:3] full scale
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_PER_BIT  = 2;
    localparam int unsigned CFG_FS_LSB   = 3;
    localparam logic [6:0]  CFG_RST      = 7'h60;
    localparam logic [1:0]  MODE_OFF     = 2'h0;
    localparam logic [1:0]  MODE_SINGLE  = 2'h1;
    localparam logic [3:0]  FS_AUTO      = 4'hc;
    localparam logic [3:0]  FS_MAX       = 4'hb;
    localparam logic [11:0] MANT_MAX     = 12'hfff;
    // status bits: [0] ready, [1] above window, [2] below window
    localparam int unsigned ST_READY     = 0;
    localparam int unsigned ST_HIGH      = 1;
    localparam int unsigned ST_LOW       = 2;
    localparam logic [19:0] HIGH_LIM_RST = 20'hfffff;
    // bus answers and serial address
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;
    localparam logic [6:0]  DEV_ADDR_DEF = 7'h44;
endpackage

// ==== rtl/almc_top.sv ====
// Purpose: conversion sequencing, window alert and result readout
// Assumes: pins synchronous to aclk, light_raw valid at all times
// Notes:   result is {range[3:0], mantissa[11:0]}, lux = 0.01*m*2^range
//
// The register addresses and register access over AXI4-Lite were decided locally.
module almc_top #(
    parameter int unsigned SHORT_CYC   = almc_pkg::SHORT_CYC,
    parameter int unsigned LONG_CYC    = almc_pkg::LONG_CYC,
    parameter int unsigned FINISH_CYC  = almc_pkg::FINISH_CYC,
    parameter int unsigned ASSESS_CYC  = almc_pkg::ASSESS_CYC,
    parameter int unsigned TIMEOUT_CYC = almc_pkg::TIMEOUT_CYC,
    parameter logic [6:0]  DEV_ADDR    = almc_pkg::DEV_ADDR_DEF
) (
    // clock, reset, enable
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    // control bus write
    input  wire logic [almc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // control bus read
    input  wire logic [almc_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // light front end
    input  wire logic [almc_pkg::RAW_W-1:0] light_raw,
    // two-wire serial pins
    input  wire logic                       scl_i,
    input  wire logic                       sda_i,
    output logic                            sda_o,
    output logic                            sda_oe_n,
    // alert and interrupt
    output logic                            alert,
    output logic                            irq
);
    // smallest range that keeps mantissa within 12 bits
    function automatic logic [3:0] range_of(input logic [19:0] r);
        range_of = almc_pkg::FS_MAX;
        for (int e = 11; e >= 0; e--)
            if ((r >> e) <= 20'h00fff)
                range_of = e[3:0];
    endfunction
    // mantissa of raw at range e, saturated
    function automatic logic [11:0] mant_of(input logic [19:0] r,
                                            input logic [3:0] e);
        logic [19:0] s;
        s = r >> e;
        mant_of = (s > 20'h00fff) ? almc_pkg::MANT_MAX : s[11:0];
    endfunction
    // byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++)
            merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    endfunction

    typedef enum logic [3:0] {
        C_IDLE   = 4'b0001,
        C_ASSESS = 4'b0010,
        C_INTEG  = 4'b0100,
        C_FINISH = 4'b1000
    } almc_conv_t;
    typedef enum logic [3:0] {
        I_IDLE = 4'b0001,
        I_ADDR = 4'b0010,
        I_ACK  = 4'b0100,
        I_TX   = 4'b1000
    } almc_ser_t;

    // registers
    logic [6:0]  cfg_q;          // mode, period, full scale
    logic [19:0] low_q, high_q;  // window limits, linear lux codes
    logic [2:0]  status_q;       // sticky events
    logic [2:0]  mask_q;         // interrupt enables
    logic [15:0] result_q;       // range and mantissa
    logic [3:0]  range_q;        // range used by conversion
    logic [19:0] raw_q;          // raw sample at integration end
    almc_conv_t  cst_q;          // conversion state
    logic [almc_pkg::CNT_W-1:0] cnt_q;
    logic        done_q;         // one-cycle result strobe
    logic        alert_q, irq_q;
    // bus slave state
    logic        aw_have_q, w_have_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // config field views
    wire [1:0] mode    = cfg_q[almc_pkg::CFG_MODE_LSB +: 2];
    wire       per_sel = cfg_q[almc_pkg::CFG_PER_BIT];
    wire [3:0] fss     = cfg_q[almc_pkg::CFG_FS_LSB +: 4];
    wire       is_auto = (fss == almc_pkg::FS_AUTO);
    wire [3:0] fs_man  = (fss > almc_pkg::FS_MAX) ? almc_pkg::FS_MAX : fss;
    wire [almc_pkg::CNT_W-1:0] integ_ld = per_sel ?
        almc_pkg::CNT_W'(LONG_CYC - 1) : almc_pkg::CNT_W'(SHORT_CYC - 1);
    wire       cnt_end = (cnt_q == '0);
    // mantissa to publish, and the published result as a linear code
    wire [11:0] mant   = mant_of(raw_q, range_q);
    // compare what was published; range_q moves on at publish time
    wire [19:0] lin    = 20'(result_q[11:0]) << result_q[15:12];
    wire        above  = lin > high_q;
    wire        below  = lin < low_q;

    // bus write decode
    wire       wr_go   = aw_have_q && w_have_q && !bvalid_q;
    wire [7:0] wa      = {waddr_q[7:2], 2'b00};
    wire       wr_cfg  = wr_go && wa == almc_pkg::OFF_CONFIG;
    wire       wr_low  = wr_go && wa == almc_pkg::OFF_LOW_LIM;
    wire       wr_high = wr_go && wa == almc_pkg::OFF_HIGH_LIM;
    wire       wr_mask = wr_go && wa == almc_pkg::OFF_MASK;
    wire       wr_ok   = wr_cfg || wr_low || wr_high || wr_mask;
    wire [31:0] cfg_m  = merge({25'h0, cfg_q}, wdata_q, wstrb_q);
    wire [31:0] low_m  = merge({12'h0, low_q}, wdata_q, wstrb_q);
    wire [31:0] high_m = merge({12'h0, high_q}, wdata_q, wstrb_q);
    wire [31:0] mask_m = merge({29'h0, mask_q}, wdata_q, wstrb_q);
    // bus read decode
    wire       rd_go   = arvalid && arready_q;
    wire [7:0] ra      = {araddr[7:2], 2'b00};
    wire       rd_stat = rd_go && ra == almc_pkg::OFF_STATUS;
    wire       rd_hit  = ra == almc_pkg::OFF_CONFIG ||
                         ra == almc_pkg::OFF_RESULT ||
                         ra == almc_pkg::OFF_LOW_LIM ||
                         ra == almc_pkg::OFF_HIGH_LIM ||
                         ra == almc_pkg::OFF_STATUS ||
                         ra == almc_pkg::OFF_MASK ||
                         ra == almc_pkg::OFF_STATE;
    wire [31:0] rd_val =
        ra == almc_pkg::OFF_CONFIG   ? {25'h0, cfg_q} :
        ra == almc_pkg::OFF_RESULT   ? {16'h0, result_q} :
        ra == almc_pkg::OFF_LOW_LIM  ? {12'h0, low_q} :
        ra == almc_pkg::OFF_HIGH_LIM ? {12'h0, high_q} :
        ra == almc_pkg::OFF_STATUS   ? {29'h0, status_q} :
        ra == almc_pkg::OFF_MASK     ? {29'h0, mask_q} :
        ra == almc_pkg::OFF_STATE    ? {23'h0, cst_q, 1'b0, range_q} :
        32'h0;

    // bus handshakes: one write, one read outstanding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
            {awready_q, wready_q, arready_q} <= 3'h7;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bresp_q <= almc_pkg::RESP_OKAY;
            rresp_q <= almc_pkg::RESP_OKAY;
            rdata_q <= 32'h0;
        end
        else if (ce)
        begin
            // capture address and data in either order
            if (awvalid && awready_q)
            begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                waddr_q   <= awaddr;
            end
            if (wvalid && wready_q)
            begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            // answer once both have arrived
            if (wr_go)
            begin
                {aw_have_q, w_have_q} <= 2'b00;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? almc_pkg::RESP_OKAY
                                  : almc_pkg::RESP_DECERR;
            end
            if (bvalid_q && bready)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            // read answers the cycle after the address
            if (rd_go)
            begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_val;
                rresp_q   <= rd_hit ? almc_pkg::RESP_OKAY
                                    : almc_pkg::RESP_DECERR;
            end
            if (rvalid_q && rready)
            begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // software registers; software write beats hardware mode clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q  <= almc_pkg::CFG_RST;
            low_q  <= 20'h0;
            high_q <= almc_pkg::HIGH_LIM_RST;
            mask_q <= 3'h0;
        end
        else if (ce)
        begin
            if (done_q && mode == almc_pkg::MODE_SINGLE)
                cfg_q[almc_pkg::CFG_MODE_LSB +: 2] <= almc_pkg::MODE_OFF;
            if (wr_cfg)
                cfg_q <= cfg_m[6:0];
            if (wr_low)
                low_q <= low_m[19:0];
            if (wr_high)
                high_q <= high_m[19:0];
            if (wr_mask)
                mask_q <= mask_m[2:0];
        end
    end

    // conversion sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cst_q    <= C_IDLE;
            cnt_q    <= '0;
            range_q  <= 4'h0;
            raw_q    <= 20'h0;
            result_q <= 16'h0;
            done_q   <= 1'b0;
        end
        else if (ce)
        begin
            done_q <= 1'b0;
            if (mode == almc_pkg::MODE_OFF ||
                (done_q && mode == almc_pkg::MODE_SINGLE))
                cst_q <= C_IDLE;
            else
                unique case (cst_q)
                    C_IDLE:
                    begin
                        if (is_auto)
                        begin
                            cst_q <= C_ASSESS;
                            cnt_q <= almc_pkg::CNT_W'(ASSESS_CYC - 1);
                        end
                        else
                        begin
                            cst_q   <= C_INTEG;
                            cnt_q   <= integ_ld;
                            range_q <= fs_man;
                        end
                    end
                    C_ASSESS:
                        if (cnt_end)
                        begin
                            range_q <= range_of(light_raw);
                            cst_q   <= C_INTEG;
                            cnt_q   <= integ_ld;
                        end
                        else
                            cnt_q <= cnt_q - 1'b1;
                    C_INTEG:
                        if (cnt_end)
                        begin
                            raw_q <= light_raw;
                            cst_q <= C_FINISH;
                            cnt_q <= almc_pkg::CNT_W'(FINISH_CYC - 1);
                        end
                        else
                            cnt_q <= cnt_q - 1'b1;
                    C_FINISH:
                        if (cnt_end)
                        begin
                            result_q <= {range_q, mant};
                            done_q   <= 1'b1;
                            cst_q    <= C_INTEG;
                            cnt_q    <= integ_ld;
                            range_q  <= is_auto ? range_of(raw_q) : fs_man;
                        end
                        else
                            cnt_q <= cnt_q - 1'b1;
                endcase
        end
    end

    // sticky events; an event wins over the read clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_q <= 3'h0;
            alert_q  <= 1'b0;
            irq_q    <= 1'b0;
        end
        else if (ce)
        begin
            status_q <= (rd_stat ? 3'h0 : status_q) |
                        ({3{done_q}} & {below, above, 1'b1});
            if (done_q)
                alert_q <= above || below;
            irq_q <= |(status_q & mask_q);
        end
    end

    // two-wire slave, read only, result high byte then low
    almc_ser_t   sst_q;
    logic        scl_q, sda_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic        rw_q, byte_q, nak_q, oe_n_q;
    logic [almc_pkg::CNT_W-1:0] to_q;
    wire scl_rise = scl_i && !scl_q;
    wire scl_fall = !scl_i && scl_q;
    wire start_c  = scl_i && scl_q && sda_q && !sda_i;
    wire stop_c   = scl_i && scl_q && !sda_q && sda_i;
    // scl held low for the timeout
    wire timeout  = (to_q == almc_pkg::CNT_W'(TIMEOUT_CYC - 1));
    wire [7:0] tx_byte = byte_q ? result_q[7:0] : result_q[15:8];

    // stuck clock counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            to_q <= '0;
        else if (ce)
            to_q <= (scl_i || timeout) ? '0 : to_q + 1'b1;
    end

    // serial state machine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sst_q  <= I_IDLE;
            {scl_q, sda_q, oe_n_q} <= 3'h7;
            {rw_q, byte_q, nak_q} <= 3'h0;
            bit_q  <= 4'h0;
            sh_q   <= 8'h00;
        end
        else if (ce)
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            // timeout or stop returns to idle
            if (timeout || stop_c)
            begin
                sst_q  <= I_IDLE;
                oe_n_q <= 1'b1;
            end
            else if (start_c)
            begin
                sst_q  <= I_ADDR;
                bit_q  <= 4'h0;
                oe_n_q <= 1'b1;
            end
            else
                unique case (sst_q)
                    I_IDLE: ;
                    I_ADDR:
                        if (scl_rise)
                        begin
                            sh_q  <= {sh_q[6:0], sda_i};
                            bit_q <= bit_q + 1'b1;
                        end
                        else if (scl_fall && bit_q == 4'h8)
                        begin
                            // acknowledge own address only
                            if (sh_q[7:1] == DEV_ADDR)
                            begin
                                sst_q  <= I_ACK;
                                oe_n_q <= 1'b0;
                                rw_q   <= sh_q[0];
                            end
                            else
                                sst_q <= I_IDLE;
                        end
                    I_ACK:
                        if (scl_rise && rw_q)
                            nak_q <= sda_i;
                        else if (scl_fall)
                        begin
                            if (rw_q && !nak_q)
                            begin
                                sst_q  <= I_TX;
                                sh_q   <= {tx_byte[6:0], 1'b0};
                                oe_n_q <= tx_byte[7];
                                byte_q <= !byte_q;
                                bit_q  <= 4'h1;
                            end
                            else
                            begin
                                sst_q  <= rw_q ? I_IDLE : I_ADDR;
                                oe_n_q <= 1'b1;
                                bit_q  <= 4'h0;
                            end
                        end
                    I_TX:
                        if (scl_fall)
                        begin
                            if (bit_q == 4'h8)
                            begin
                                sst_q  <= I_ACK;
                                oe_n_q <= 1'b1;
                                nak_q  <= 1'b0;
                            end
                            else
                            begin
                                oe_n_q <= sh_q[7];
                                sh_q   <= {sh_q[6:0], 1'b0};
                                bit_q  <= bit_q + 1'b1;
                            end
                        end
                endcase
            if (start_c && !(timeout || stop_c))
                byte_q <= 1'b0;
        end
    end

    // outputs straight from flops, sda_o tied low
    assign awready  = awready_q;
    assign wready   = wready_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign arready  = arready_q;
    assign rvalid   = rvalid_q;
    assign rdata    = rdata_q;
    assign rresp    = rresp_q;
    assign sda_o    = 1'b0;
    assign sda_oe_n = oe_n_q;
    assign alert    = alert_q;
    assign irq      = irq_q;
endmodule

// ==== tb/almc_props.sv ====
// Purpose: port checks of the light measurement control
// Assumes: one clock, aresetn synchronous and active low
// Notes:   bound to almc_top from the bench top file
module almc_props #(
    parameter int unsigned TIMEOUT_CYC = 100
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // serial pins and flags
    input wire logic scl_i,
    input wire logic sda_oe_n,
    input wire logic alert,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles with the serial clock held low
    logic [31:0] low_q;
    always_ff @(posedge aclk)
        low_q <= (!aresetn || scl_i) ? 32'h0 : low_q + 32'h1;
    property p_rst;
        $rose(aresetn) |-> !irq && !alert && sda_oe_n && !bvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_bhold; bvalid && !bready |=> bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer lost");
    property p_rhold; rvalid && !rready |=> rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read answer lost");
    property p_rans; arvalid && arready |=> rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans; awvalid && awready |-> ##[1:8] bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_awlow; awvalid && awready |=> !awready; endproperty
    a_awlow: assert property (p_awlow) else $error("second write taken");
    property p_tmo; low_q > TIMEOUT_CYC + 2 |-> sda_oe_n; endproperty
    a_tmo: assert property (p_tmo) else $error("data held past timeout");
    property p_sda; !$stable(sda_oe_n) |-> !$past(scl_i); endproperty
    a_sda: assert property (p_sda) else $error("sda moved in scl high");
endmodule

// ==== tb/almc_host.sv ====
// Purpose: two-wire master model reading the result
// Assumes: pull-up on the data line, clock always driven
// Notes:   one bit takes 16 aclk cycles
module almc_host #(
    parameter logic [6:0] ADDR = 7'h44
) (
    input  wire logic aclk,
    input  wire logic sda_i,
    output logic      scl,
    output logic      sda
);
    // idle bus is high on both lines
    initial {scl, sda} = 2'h3;
    // one bit, data sampled mid high phase
    task automatic bt(input logic o, output logic b);
        sda <= o;
        repeat (4) @(posedge aclk);
        scl <= 1'b1;
        repeat (4) @(posedge aclk);
        b = sda_i;
        repeat (4) @(posedge aclk);
        scl <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    // start, address, two bytes or a stall, stop
    task automatic rd16(input int stall, output logic [15:0] v,
                        output logic ack);
        logic       b;
        logic [7:0] ab;
        ab = {ADDR, 1'b1};
        sda <= 1'b0;
        repeat (8) @(posedge aclk);
        scl <= 1'b0;
        for (int i = 7; i >= 0; i--) bt(ab[i], b);
        bt(1'b1, ack);
        repeat (stall) @(posedge aclk);
        // ack after high byte, nak after low byte
        for (int i = 17; i >= 0 && stall == 0; i--)
        begin
            bt(i == 9 ? 1'b0 : 1'b1, b);
            if (i != 9 && i != 0) v = {v[14:0], b};
        end
        sda <= 1'b0;
        repeat (4) @(posedge aclk);
        scl <= 1'b1;
        repeat (4) @(posedge aclk);
        sda <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the light measurement control
// Assumes: counts shortened to 200, 400, 30, 20 and 100 cycles
// Notes:   host model reads results over the two-wire bus
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SH = 200, LG = 400, FN = 30, AS = 20, TO = 100;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sda_o, sda_oe_n;
    logic        alert, irq, scl, hsda, sda, ack;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, cfg;
    logic [19:0] light_raw;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] v;
    int          bad_count, comparisons, n, e;
    // open-drain data line with pull-up
    assign sda = hsda & (sda_oe_n | sda_o);
    almc_top #(.SHORT_CYC(SH), .LONG_CYC(LG), .FINISH_CYC(FN),
        .ASSESS_CYC(AS), .TIMEOUT_CYC(TO)) u_almc_top (.aclk, .aresetn,
        .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .light_raw,
        .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n, .alert, .irq);
    almc_host u_almc_host (.aclk, .sda_i(sda), .scl, .sda(hsda));
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(string s, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", s, x, g);
        end
    endtask
    // one bus transfer, write when w is set
    task automatic bus(logic w, logic [7:0] a, logic [31:0] x);
        // let an edge pass so no handshake signal is set twice at once
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, x};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(w ? bvalid : rvalid));
        {d, rs} = {rdata, w ? bresp : rresp};
        {bready, rready} <= 2'h0;
    endtask
    // expected result: smallest range keeping mantissa in 12 bits
    function automatic logic [31:0] exp_res(logic [19:0] r);
        logic [3:0] k;
        k = 4'h0;
        while ((r >> k) > 20'hfff) k++;
        return {16'h0, k, 12'(r >> k)};
    endfunction
    task automatic wirq;
        for (n = 0; irq !== 1'b1 && n < 2000; n++) @(posedge aclk);
    endtask
    task automatic results;
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
        {awaddr, araddr, wdata, light_raw} = '0;
        bad_count = 0;
        comparisons = 0;
        n = $urandom(32'hace5563e);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, almc_pkg::OFF_CONFIG, 0);
        chk("config", 32'h60, d);
        repeat (300) @(posedge aclk);
        bus(0, almc_pkg::OFF_STATUS, 0);
        chk("idle status", 0, d);
        bus(0, 8'h1c, 0);
        chk("unmapped", almc_pkg::RESP_DECERR, rs);
        bus(1, almc_pkg::OFF_RESULT, 1);
        chk("ro", almc_pkg::RESP_DECERR, rs);
        bus(1, almc_pkg::OFF_MASK, 1);
        // manual short, manual long, auto range with window
        for (int i = 0; i < 3; i++)
        begin
            // manual runs stay in range 0, the auto run needs range 1 up
            light_raw <= i == 2 ? 20'($urandom) | 20'h01000
                                : 20'($urandom) & 20'h00fff;
            if (i == 2) bus(1, almc_pkg::OFF_HIGH_LIM, 0);
            cfg = {25'h0, i == 2 ? 4'hc : 4'h0, i == 1, 2'h1};
            bus(1, almc_pkg::OFF_CONFIG, cfg);
            wirq;
            e = (i == 1 ? LG : SH) + (i == 2 ? AS : 0) + FN;
            chk("time", 1, 32'(n + 6 > e && n < e + 6));
            bus(0, almc_pkg::OFF_RESULT, 0);
            chk("result", exp_res(light_raw), d);
            chk("alert", 32'(i == 2), 32'(alert));
            bus(0, almc_pkg::OFF_CONFIG, 0);
            chk("stop", cfg & ~32'h3, d);
            bus(0, almc_pkg::OFF_STATUS, 0);
            chk("status", {i == 2, 1'b1}, d);
            repeat (2) @(posedge aclk);
            chk("irq", 0, 32'(irq));
        end
        light_raw <= 20'h00abc;
        bus(1, almc_pkg::OFF_CONFIG, 32'h2);
        wirq;
        bus(0, almc_pkg::OFF_STATUS, 0);
        repeat (2) @(posedge aclk);
        wirq;
        chk("continuous", 1, 32'(n + 12 > SH + FN && n < SH + FN + 8));
        bus(1, almc_pkg::OFF_CONFIG, 0);
        // a low acknowledge bit means the address was taken
        u_almc_host.rd16(0, v, ack);
        chk("serial", 32'h0abc, {ack, v});
        u_almc_host.rd16(TO + 20, v, ack);
        u_almc_host.rd16(0, v, ack);
        chk("recover", 32'h0abc, {ack, v});
        results();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        results();
    end
endmodule
bind almc_top almc_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_almc_props (.aclk,
    .aresetn, .awvalid, .awready, .bvalid, .bready, .arvalid, .arready,
    .rvalid, .rready, .scl_i, .sda_oe_n, .alert, .irq);
